// >>> rtl/bcd_preset_programmable_divider.sv
`default_nettype none
module bcd_preset_programmable_divider
	import divider_pkg::*;
(
	input  wire logic                clk_i,
	input  wire logic                rstn_i,
	input  wire logic                ce_i,
	input  wire logic [PRESET_W-1:0] frequency_preset_digits_i,
	output logic                     divided_output_o,
	output logic                     sampler_trigger_o
);
	// ==========================================================
	// Helpers.
	function automatic logic digit_match(input logic [BCD_W-1:0] digit, input logic [BCD_W-1:0] mask);
		digit_match = ((digit & mask) == mask);
	endfunction

	// Decimal weight of the two preset digits, for the period checks below.
	function automatic logic [PERIOD_W-1:0] bcd_value(input logic [PRESET_W-1:0] digits);
		bcd_value = PERIOD_W'(digits[PRESET_W-1:BCD_W]) * PERIOD_W'(DIGIT_MAX + 4'h1) + PERIOD_W'(digits[BCD_W-1:0]);
	endfunction

	// ==========================================================
	// Declarations.
	logic [BCD_W-1:0] units_digit;
	logic [BCD_W-1:0] tens_digit;
	logic             units_carry;
	logic             tens_carry;
	logic             hundreds_ff_low_r;
	logic             hundreds_ff_low_nxt;
	logic             hundreds_ff_high_r;
	logic             hundreds_ff_high_nxt;
	logic             terminal_ff_r;
	logic             terminal_ff_nxt;
	logic             restart_seq_ff_r;
	logic             restart_seq_ff_nxt;
	logic             sample_seq_ff_r;
	logic             sample_seq_ff_nxt;
	logic             resume_r;
	logic             resume_nxt;
	logic             trigger_r;
	logic             trigger_nxt;
	logic             count_enable_gate;
	logic             tens_decode_gate;
	logic             detect_tens;
	logic             detect_units;
	logic             detect_all;
	logic             load_preset;

	// ==========================================================
	// Count chain.
	// The gate is closed by the active terminal flip-flop, by either sequencing flip-flop and by the
	// suppressed pulse after restart; that last term gives the third restart cycle.
	assign count_enable_gate = !terminal_ff_r && !restart_seq_ff_r && !sample_seq_ff_r && !resume_r;
	assign load_preset       = restart_seq_ff_r;

	bcd_decade u_units (
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.load_i     (load_preset),
		.load_val_i (frequency_preset_digits_i[BCD_W-1:0]),
		.count_i    (count_enable_gate),
		.digit_o    (units_digit),
		.carry_o    (units_carry)
	);

	bcd_decade u_tens (
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.load_i     (load_preset),
		.load_val_i (frequency_preset_digits_i[PRESET_W-1:BCD_W]),
		.count_i    (units_carry),
		.digit_o    (tens_digit),
		.carry_o    (tens_carry)
	);

	// Ripple edges of the hundreds pair become same-clock enables, so no derived clocks exist.
	always_comb begin
		hundreds_ff_low_nxt  = hundreds_ff_low_r;
		hundreds_ff_high_nxt = hundreds_ff_high_r;
		if (load_preset) begin
			hundreds_ff_low_nxt  = 1'b0;
			hundreds_ff_high_nxt = 1'b0;
		end else if (tens_carry) begin
			hundreds_ff_low_nxt = !hundreds_ff_low_r;
			if (hundreds_ff_low_r) begin
				hundreds_ff_high_nxt = !hundreds_ff_high_r;
			end
		end
	end

	// ==========================================================
	// Terminal detect.
	// The suppressed pulse forces the units decode off, so a preset of three cannot arm early.
	assign tens_decode_gate = hundreds_ff_high_r && !hundreds_ff_low_r;
	assign detect_tens      = tens_decode_gate && digit_match(tens_digit, TENS_SENSE);
	assign detect_units     = digit_match(units_digit, UNITS_SENSE) && !resume_r;
	assign detect_all       = detect_tens && detect_units;

	// ==========================================================
	// Terminal and sequencing flip-flops.
	always_comb begin
		// J is the detect term and K is tied high: toggle when armed, otherwise release.
		terminal_ff_nxt    = detect_all ? !terminal_ff_r : 1'b0;
		restart_seq_ff_nxt = restart_seq_ff_r;
		sample_seq_ff_nxt  = sample_seq_ff_r;
		if (terminal_ff_nxt) begin
			restart_seq_ff_nxt = 1'b1;
			sample_seq_ff_nxt  = 1'b1;
		end else if (!terminal_ff_r) begin
			restart_seq_ff_nxt = 1'b0;
			sample_seq_ff_nxt  = 1'b0;
		end
		resume_nxt  = restart_seq_ff_r && !restart_seq_ff_nxt;
		trigger_nxt = sample_seq_ff_nxt && !sample_seq_ff_r;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			hundreds_ff_low_r  <= 1'b0;
			hundreds_ff_high_r <= 1'b0;
			terminal_ff_r      <= 1'b0;
			restart_seq_ff_r   <= 1'b0;
			sample_seq_ff_r    <= 1'b0;
			resume_r           <= 1'b0;
			trigger_r          <= 1'b0;
		end else if (ce_i) begin
			hundreds_ff_low_r  <= hundreds_ff_low_nxt;
			hundreds_ff_high_r <= hundreds_ff_high_nxt;
			terminal_ff_r      <= terminal_ff_nxt;
			restart_seq_ff_r   <= restart_seq_ff_nxt;
			sample_seq_ff_r    <= sample_seq_ff_nxt;
			resume_r           <= resume_nxt;
			trigger_r          <= trigger_nxt;
		end
	end

	// The divided output is the sample flip-flop itself; ratio follows from the preset load.
	assign divided_output_o  = sample_seq_ff_r;
	assign sampler_trigger_o = trigger_r;

	// ==========================================================
	// Checks.
	logic [PERIOD_W-1:0] period_cnt_r;
	logic                seen_trigger_r;
	logic [PERIOD_W-1:0] ratio_r;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			period_cnt_r   <= '0;
			seen_trigger_r <= 1'b0;
			ratio_r        <= PERIOD_W'(TERMINAL_COUNT);
		end else if (ce_i) begin
			period_cnt_r   <= trigger_r ? PERIOD_W'(1) : period_cnt_r + PERIOD_W'(1);
			seen_trigger_r <= seen_trigger_r || trigger_r;
			// The ratio follows the digits actually loaded, not the pins at the trigger.
			if (load_preset) begin
				ratio_r <= PERIOD_W'(TERMINAL_COUNT) - bcd_value(frequency_preset_digits_i);
			end
		end
	end

	a_first_trigger: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(trigger_r) && !seen_trigger_r |-> period_cnt_r == PERIOD_W'(FIRST_TRIGGER))
		else $error("first trigger not after input cycle 294");
	a_trigger_spacing: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(trigger_r) && seen_trigger_r |-> period_cnt_r == ratio_r)
		else $error("trigger spacing does not match the loaded preset");
	a_term_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ce_i && !detect_all |=> !terminal_ff_r)
		else $error("terminal flip-flop moved without all detect inputs");
	a_seq_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(terminal_ff_r) |-> restart_seq_ff_r && sample_seq_ff_r)
		else $error("sequencing flip-flops not set with terminal");
	a_gate_closed: assert property (@(posedge clk_i) disable iff (!rstn_i)
		terminal_ff_r || sample_seq_ff_r |-> !count_enable_gate)
		else $error("count gate open during terminal sequence");
	a_preset_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ce_i && restart_seq_ff_r |=> {tens_digit, units_digit} == $past(frequency_preset_digits_i))
		else $error("preset not loaded during restart");
	a_restart_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ce_i && restart_seq_ff_r && !terminal_ff_r |=> !restart_seq_ff_r ##0 resume_r ##1 count_enable_gate || !ce_i)
		else $error("restart sequence did not reopen the gate");
	a_suppressed_pulse: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ce_i && resume_r |=> $stable(units_digit))
		else $error("suppressed pulse advanced the units decade");
	a_hundreds_guard: assert property (@(posedge clk_i) disable iff (!rstn_i)
		detect_tens |-> hundreds_ff_high_r && tens_digit == TENS_SENSE)
		else $error("tens decode active below 200");
	a_trigger_width: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ce_i && trigger_r |=> !trigger_r)
		else $error("sampler trigger longer than one input cycle");
	a_term_release: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$fell(terminal_ff_r) |-> sample_seq_ff_r && !count_enable_gate)
		else $error("count gate reopened when the terminal flip-flop released");

	c_first_trigger: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(trigger_r) && !seen_trigger_r);
	c_second_trigger: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(trigger_r) && seen_trigger_r);
	c_preset_run: cover property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(trigger_r) && frequency_preset_digits_i != '0);
	c_stall_mid_count: cover property (@(posedge clk_i) disable iff (!rstn_i) !ce_i && count_enable_gate);
endmodule
`default_nettype wire

// >>> rtl/divider_pkg.sv
`default_nettype none
package divider_pkg;
	localparam int unsigned BCD_W          = 4;
	localparam int unsigned PRESET_W       = 2 * BCD_W;
	localparam logic [3:0]  DIGIT_MAX      = 4'h9;
	localparam logic [3:0]  DIGIT_ZERO     = 4'h0;
	localparam logic [3:0]  UNITS_SENSE    = 4'h3;
	localparam logic [3:0]  TENS_SENSE     = 4'h9;
	localparam int unsigned TERMINAL_COUNT = 297;
	localparam int unsigned FIRST_TRIGGER  = 294;
	localparam int unsigned PERIOD_W       = 9;
endpackage
`default_nettype wire

// >>> rtl/bcd_decade.sv
`default_nettype none
module bcd_decade
	import divider_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             ce_i,
	input  wire logic             load_i,
	input  wire logic [BCD_W-1:0] load_val_i,
	input  wire logic             count_i,
	output logic      [BCD_W-1:0] digit_o,
	output logic                  carry_o
);
	// ==========================================================
	// Decade state.
	logic [BCD_W-1:0] digit_r;
	logic [BCD_W-1:0] digit_nxt;

	always_comb begin
		digit_nxt = digit_r;
		if (load_i) begin
			digit_nxt = load_val_i;
		end else if (count_i) begin
			digit_nxt = (digit_r == DIGIT_MAX) ? DIGIT_ZERO : digit_r + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			digit_r <= DIGIT_ZERO;
		end else if (ce_i) begin
			digit_r <= digit_nxt;
		end
	end

	// The carry marks the wrap from nine, the falling edge of the digit's eight bit.
	assign carry_o = count_i && !load_i && (digit_r == DIGIT_MAX);
	assign digit_o = digit_r;
endmodule
`default_nettype wire

// >>> test/vco_sampler_model.sv
`default_nettype none
// ==========================================================================
// Oscillator and sampler stand-in.
module vco_sampler_model (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        stall_i,
	input  wire logic        trigger_i,
	output logic             ce_o,
	output logic [15:0]      gap_o,
	output logic [15:0]      n_trig_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        trig_q_r;
	logic [15:0] cnt_r;
	// A stalled oscillator gives no input cycle, so gaps count enabled edges only.
	assign ce_o = !stall_i;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			trig_q_r <= 1'b0;
			cnt_r    <= 16'h0000;
			gap_o    <= 16'h0000;
			n_trig_o <= 16'h0000;
		end else begin
			trig_q_r <= trigger_i;
			// A frozen trigger stays high, so only its rise is one sample.
			if (trigger_i && !trig_q_r) begin
				gap_o    <= cnt_r;
				cnt_r    <= {15'h0000, ce_o};
				n_trig_o <= n_trig_o + 16'h0001;
			end else begin
				cnt_r <= cnt_r + {15'h0000, ce_o};
			end
		end
	end
endmodule
`default_nettype wire

// >>> test/bcd_preset_programmable_divider_bench.sv
`default_nettype none
module bcd_preset_programmable_divider_bench import divider_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                clk;
	logic                rstn;
	logic                stall;
	logic                ce;
	logic [PRESET_W-1:0] preset;
	logic                div_out;
	logic                trig;
	logic [15:0]         gap;
	logic [15:0]         n_trig;
	int                  n_errors;
	int                  n_compared;
	// ======================================================================
	// Design and far side.
	bcd_preset_programmable_divider i_bcd_preset_programmable_divider (
		.clk_i                     (clk),
		.rstn_i                    (rstn),
		.ce_i                      (ce),
		.frequency_preset_digits_i (preset),
		.divided_output_o          (div_out),
		.sampler_trigger_o         (trig)
	);
	vco_sampler_model i_vco_sampler_model (
		.clk_i     (clk),
		.rstn_i    (rstn),
		.stall_i   (stall),
		.trigger_i (trig),
		.ce_o      (ce),
		.gap_o     (gap),
		.n_trig_o  (n_trig)
	);
	initial begin
		clk = 1'b0;
		forever #4 clk = !clk;
	end
	// ======================================================================
	// Shared tasks.
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %0d seen %0d", what, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_trig(output int cyc);
		logic [15:0] start;
		start = n_trig;
		cyc = 0;
		while (n_trig === start && cyc < 1000) begin
			step(1);
			cyc++;
		end
		check("trigger seen", 16'(cyc < 1000), 16'h0001);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ======================================================================
	// Scenarios.
	task automatic first_trigger();
		int i;
		i = 0;
		while (trig !== 1'b1 && i < 400) begin
			step(1);
			i++;
		end
		check("first trigger edge", 16'(i), 16'(FIRST_TRIGGER));
		check("output at trigger", {15'h0000, div_out}, 16'h0001);
		step(1);
		check("trigger width", {15'h0000, trig}, 16'h0000);
		check("output second cycle", {15'h0000, div_out}, 16'h0001);
		step(1);
		check("output cleared", {15'h0000, div_out}, 16'h0000);
		check("first gap", gap, 16'(FIRST_TRIGGER));
	endtask
	task automatic preset_table();
		logic [7:0] p [4];
		int c;
		logic [15:0] prev;
		logic [15:0] exp;
		p = '{8'h99, 8'h45, 8'h01, 8'h00};
		prev = 16'(TERMINAL_COUNT);
		wait_trig(c);
		check("zero preset gap", gap, prev);
		foreach (p[k]) begin
			step(10);
			preset = p[k];
			exp = 16'(TERMINAL_COUNT - (10 * p[k][7:4] + p[k][3:0]));
			wait_trig(c);
			check("gap before reload", gap, prev);
			wait_trig(c);
			check("preset gap", gap, exp);
			prev = exp;
		end
	endtask
	task automatic stall_count();
		int c;
		logic [15:0] n_before;
		wait_trig(c);
		// The stall covers the edge at which a free-running count would fire.
		step(280);
		stall = 1'b1;
		n_before = n_trig;
		step(40);
		check("trigger during stall", {15'h0000, trig}, 16'h0000);
		check("triggers in stall", n_trig, n_before);
		stall = 1'b0;
		wait_trig(c);
		check("stalled gap", gap, 16'(TERMINAL_COUNT));
		check("stalled clocks", 16'(c + 320), 16'(TERMINAL_COUNT + 40));
	endtask
	task automatic mid_reset();
		int c;
		step(10);
		preset = 8'h50;
		wait_trig(c);
		check("output before reset", {15'h0000, div_out}, 16'h0001);
		rstn = 1'b0;
		step(1);
		check("output in reset", {15'h0000, div_out}, 16'h0000);
		rstn = 1'b1;
		wait_trig(c);
		check("gap after reset", gap, 16'(FIRST_TRIGGER));
		wait_trig(c);
		check("preset after reset", gap, 16'(TERMINAL_COUNT - 50));
	endtask
	initial begin
		n_errors = 0;
		n_compared = 0;
		rstn = 1'b0;
		stall = 1'b0;
		preset = 8'h00;
		step(5);
		rstn = 1'b1;
		first_trigger();
		preset_table();
		stall_count();
		mid_reset();
		complete_run();
	end
	// The whole sequence needs about 4000 cycles; five times that means a hang.
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("wrong value run time expected finish seen timeout");
		complete_run();
	end
endmodule
`default_nettype wire
